// *** src/psm_port.sv ***
// Programmable synchronous memory port: register file, link clock edge finder, access sequencer
//
// Our own choices: the address map and strobed register access.
module psm_port
    import psm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [REG_AW-1:0] reg_addr,
    input wire logic [REG_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [REG_DW-1:0] reg_rdata,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [SPACE_W-1:0] req_space,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [BE_W-1:0] req_be,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    input wire logic ext_clock_out_one,
    input wire logic ext_clock_out_two,
    output logic [SPACE_N-1:0] space_chip_enable_n,
    output logic [BE_W-1:0] byte_enable_n,
    output logic [ADDR_W-1:0] ext_address,
    input wire logic [DATA_W-1:0] ext_data_i,
    output logic [DATA_W-1:0] ext_data_o,
    output logic ext_data_oe,
    output logic strobe_read_enable_n,
    output logic sync_output_enable_n,
    output logic sync_write_enable_n
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [SEC_W-1:0] sec_ff [SPACE_N];
    logic [REG_DW-1:0] rdata_ff;
    logic [1:0] clk_meta_ff;
    logic [1:0] clk_sync_ff;
    logic [1:0] clk_prev_ff;
    logic [DATA_W-1:0] data_meta_ff;
    logic [DATA_W-1:0] data_sync_ff;
    psm_state_e state_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [SEC_W-1:0] cfg_ff;
    logic [SPACE_W-1:0] space_ff;
    logic wr_ff;
    logic ready_ff;
    logic rsp_valid_ff;
    logic [DATA_W-1:0] rsp_rdata_ff;
    logic [SPACE_N-1:0] ce_n_ff;
    logic [BE_W-1:0] be_n_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [DATA_W-1:0] dout_ff;
    logic doe_ff;
    logic strobe_n_ff;
    logic oe_n_ff;
    logic we_n_ff;
    logic clk_sel;
    logic edge_c;
    logic [LAT_W-1:0] rl_cur;
    logic [LAT_W-1:0] wl_cur;
    logic [LAT_W-1:0] wl_req;
    logic chip_enable_extend_cur;
    logic strb_cur;
    logic strb_req;
    logic last_edge;

    // ****************************************************************
    // Register file
    // ****************************************************************
    // One secondary control word per space
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < SPACE_N; i++)
            begin
                sec_ff[i] <= SEC_RESET;
            end
        end
        else if (reg_wr)
        begin
            for (int i = 0; i < SPACE_N; i++)
            begin
                if (reg_addr == OFF_SEC[i])
                begin
                    sec_ff[i] <= reg_wdata[SEC_W-1:0]; // R8
                end
            end
        end
    end

    // Read data stands one cycle after the strobe, zero otherwise and for unmapped offsets
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rdata_ff <= '0;
        end
        else
        begin
            rdata_ff <= '0;
            if (reg_rd)
            begin
                for (int i = 0; i < SPACE_N; i++)
                begin
                    if (reg_addr == OFF_SEC[i])
                    begin
                        rdata_ff <= {{(REG_DW-SEC_W){1'b0}}, sec_ff[i]};
                    end
                end
                if (reg_addr == OFF_STATUS)
                begin
                    rdata_ff[STAT_BUSY_BIT] <= (state_ff != ST_IDLE);
                    rdata_ff[STAT_SPACE_LSB +: SPACE_W] <= space_ff;
                    rdata_ff[STAT_WRITE_BIT] <= wr_ff;
                end
            end
        end
    end

    // ****************************************************************
    // Link clock and read data synchronisers
    // ****************************************************************
    // Data goes through the same two stages as the clocks so both stay aligned
    // Clock stages reset high: a link clock high at release must not look like a rising edge
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            clk_meta_ff <= '1;
            clk_sync_ff <= '1;
            clk_prev_ff <= '1;
            data_meta_ff <= '0;
            data_sync_ff <= '0;
        end
        else
        begin
            clk_meta_ff <= {ext_clock_out_two, ext_clock_out_one};
            clk_sync_ff <= clk_meta_ff;
            clk_prev_ff <= clk_sync_ff;
            data_meta_ff <= ext_data_i;
            data_sync_ff <= data_meta_ff;
        end
    end

    // Clock choice follows the requested space while idle, the latched one during an access
    always_comb
    begin
        clk_sel = (state_ff == ST_IDLE) ? sec_ff[req_space][CLKSEL_BIT] : cfg_ff[CLKSEL_BIT];
        edge_c = clk_sync_ff[clk_sel] & ~clk_prev_ff[clk_sel]; // R7
    end

    // Fields of the latched configuration, and of the requested space's word (wl_req, strb_req)
    assign rl_cur = cfg_ff[RL_LSB +: LAT_W];
    assign wl_cur = cfg_ff[WL_LSB +: LAT_W];
    assign chip_enable_extend_cur = cfg_ff[CHIP_ENABLE_EXTEND_BIT];
    assign strb_cur = cfg_ff[STRB_BIT];
    assign wl_req = sec_ff[req_space][WL_LSB +: LAT_W];
    assign strb_req = sec_ff[req_space][STRB_BIT];

    // Last link edge of the access: data beat of a write or capture of a read
    assign last_edge = wr_ff ? (cnt_ff == {1'b0, wl_cur}) : (cnt_ff == {1'b0, rl_cur}); // R12

    // ****************************************************************
    // Access sequencer
    // ****************************************************************
    // All but the one-cycle ready and response pulses moves only on a detected edge, so pins never change between edges
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_ff <= ST_IDLE;
            cnt_ff <= '0;
            cfg_ff <= SEC_RESET;
            space_ff <= '0;
            wr_ff <= 1'b0;
            ready_ff <= 1'b0;
            rsp_valid_ff <= 1'b0;
            rsp_rdata_ff <= '0;
            ce_n_ff <= '1;
            be_n_ff <= '1;
            addr_ff <= '0;
            dout_ff <= '0;
            doe_ff <= 1'b0;
            strobe_n_ff <= 1'b1;
            oe_n_ff <= 1'b1;
            we_n_ff <= 1'b1;
        end
        else
        begin
            ready_ff <= 1'b0;
            rsp_valid_ff <= 1'b0;
            if (edge_c) // R10
            begin
                unique case (state_ff)
                    ST_IDLE:
                    begin
                        if (req_valid)
                        begin
                            state_ff <= ST_ACT;
                            cnt_ff <= '0;
                            cfg_ff <= sec_ff[req_space];
                            space_ff <= req_space;
                            wr_ff <= req_write;
                            ready_ff <= 1'b1;
                            ce_n_ff <= ~(SPACE_N'(1) << req_space);
                            be_n_ff <= ~req_be;
                            addr_ff <= req_addr;
                            dout_ff <= req_wdata;
                            // FIFO read enable only pulses on reads; address strobe on every command
                            strobe_n_ff <= strb_req & req_write; // R5 R6 R11
                            oe_n_ff <= req_write; // R11
                            we_n_ff <= ~req_write; // R11
                            doe_ff <= req_write && (wl_req == '0); // R2 R12
                        end
                    end
                    ST_ACT:
                    begin
                        cnt_ff <= cnt_ff + CNT_W'(1);
                        strobe_n_ff <= 1'b1;
                        we_n_ff <= 1'b1;
                        // Without extension the enable lasts only the command cycle
                        if (!chip_enable_extend_cur || wr_ff)
                        begin
                            ce_n_ff <= '1; // R3
                        end
                        if (wr_ff && (cnt_ff + CNT_W'(1) == {1'b0, wl_cur}))
                        begin
                            doe_ff <= 1'b1; // R2 R12
                        end
                        if (last_edge)
                        begin
                            doe_ff <= 1'b0;
                            oe_n_ff <= 1'b1;
                            ce_n_ff <= '1; // R4
                            if (!wr_ff)
                            begin
                                rsp_rdata_ff <= data_sync_ff; // R1 R9 R12
                                rsp_valid_ff <= 1'b1;
                            end
                            if (strb_cur)
                            begin
                                state_ff <= ST_IDLE; // R6
                            end
                            else
                            begin
                                state_ff <= ST_DESEL;
                                strobe_n_ff <= 1'b0; // R5
                            end
                        end
                    end
                    ST_DESEL:
                    begin
                        strobe_n_ff <= 1'b1;
                        state_ff <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign reg_rdata = rdata_ff;
    assign req_ready = ready_ff;
    assign rsp_valid = rsp_valid_ff;
    assign rsp_rdata = rsp_rdata_ff;
    assign space_chip_enable_n = ce_n_ff;
    assign byte_enable_n = be_n_ff;
    assign ext_address = addr_ff;
    assign ext_data_o = dout_ff;
    assign ext_data_oe = doe_ff;
    assign strobe_read_enable_n = strobe_n_ff;
    assign sync_output_enable_n = oe_n_ff;
    assign sync_write_enable_n = we_n_ff;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_deselect;
        (state_ff == ST_DESEL) && !strobe_n_ff && (&ce_n_ff);
    endsequence

    sequence s_finish_sram;
        edge_c && (state_ff == ST_ACT) && last_edge && !strb_cur;
    endsequence

    property p_read_latency;
        rsp_valid_ff |-> $past(edge_c) && ($past(cnt_ff) == {1'b0, $past(rl_cur)}) && !wr_ff;
    endproperty
    a_read_latency: assert property (p_read_latency) else $error("read data taken at wrong latency"); // R1

    property p_write_latency;
        ($rose(doe_ff) && $past(state_ff) == ST_ACT) |-> ($past(cnt_ff) + CNT_W'(1) == {1'b0, wl_cur});
    endproperty
    a_write_latency: assert property (p_write_latency) else $error("write data driven at wrong latency"); // R2

    property p_ce_short;
        ((state_ff == ST_ACT) && (cnt_ff != '0) && !chip_enable_extend_cur) |-> (&ce_n_ff);
    endproperty
    a_ce_short: assert property (p_ce_short) else $error("chip enable held past command"); // R3

    property p_ce_follows_oe;
        ((state_ff == ST_ACT) && chip_enable_extend_cur && !wr_ff) |-> ((&ce_n_ff) == oe_n_ff);
    endproperty
    a_ce_follows_oe: assert property (p_ce_follows_oe) else $error("chip enable not tracking output enable"); // R4

    property p_deselect;
        s_finish_sram |=> s_deselect;
    endproperty
    a_deselect: assert property (p_deselect) else $error("deselect cycle missing"); // R5

    // Deselect lasts a whole link period, so it only ends on the next detected edge
    property p_deselect_end;
        s_deselect |=> if ($past(edge_c)) (strobe_n_ff && state_ff == ST_IDLE) else s_deselect;
    endproperty
    a_deselect_end: assert property (p_deselect_end) else $error("deselect cycle wrong length"); // R5

    property p_no_deselect;
        ((state_ff == ST_ACT) && strb_cur) |=> (state_ff != ST_DESEL);
    endproperty
    a_no_deselect: assert property (p_no_deselect) else $error("deselect inserted in FIFO mode"); // R6

    property p_pins_on_edge;
        $changed({ce_n_ff, be_n_ff, addr_ff, doe_ff, strobe_n_ff, oe_n_ff, we_n_ff}) |-> $past(edge_c);
    endproperty
    a_pins_on_edge: assert property (p_pins_on_edge) else $error("pin changed without clock edge"); // R10

    property p_clock_choice;
        ((state_ff != ST_IDLE) && clk_sync_ff[~cfg_ff[CLKSEL_BIT]] && !clk_prev_ff[~cfg_ff[CLKSEL_BIT]]
            && !edge_c) |=> $stable(cnt_ff);
    endproperty
    a_clock_choice: assert property (p_clock_choice) else $error("unselected clock moved the sequencer"); // R7

    property p_config_store;
        (reg_wr && reg_addr == OFF_SEC[1]) |=> (sec_ff[1] == $past(reg_wdata[SEC_W-1:0]));
    endproperty
    a_config_store: assert property (p_config_store) else $error("secondary control not stored"); // R8

    property p_capture_edge;
        $changed(rsp_rdata_ff) |-> $past(edge_c) && rsp_valid_ff;
    endproperty
    a_capture_edge: assert property (p_capture_edge) else $error("read data captured off edge"); // R9

    property p_shared_pins;
        !(!oe_n_ff && !we_n_ff) && !(!oe_n_ff && doe_ff);
    endproperty
    a_shared_pins: assert property (p_shared_pins) else $error("output and write enable both active"); // R11

    property p_write_beat;
        (edge_c && state_ff == ST_ACT && wr_ff && last_edge) |=> !doe_ff && (&ce_n_ff) ##1 !doe_ff;
    endproperty
    a_write_beat: assert property (p_write_beat) else $error("write data not released after beat"); // R12

endmodule : psm_port

// *** src/psm_pkg.sv ***
// Constants, field layout and state type of the programmable synchronous memory port
// Notes on behaviour
// R1 - Read latency is programmable to zero, one, two or three interface clock cycles.
// R2 - Write latency is programmable to zero, one, two or three interface clock cycles.
// R3 - With chip-enable extension off, the space chip enable drops right after the last command is issued.
// R4 - With chip-enable extension on, the space chip enable stays asserted exactly while output enable is. On writes the code drops it after the command cycle.
// R5 - With strobe function 0 the shared strobe is an address strobe and deselect cycles are inserted.
// R6 - With strobe function 1 the shared strobe is a FIFO read enable and no deselect cycle is inserted.
// R7 - Software picks which of the two external clocks times the interface; all pins follow that clock.
// R8 - Latency, extension, strobe function and clock select live in a secondary control register per space.
// R9 - Read data is captured on the rising edge of the selected clock; the memory must hold it valid there.
// R10 - Every memory-side output changes only after a rising edge of the selected clock.
// R11 - The shared control pins serve as strobe, output enable and write enable during these accesses.
// R12 - Read data is taken read-latency cycles after the command; write data is driven write-latency cycles after it.
package psm_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int DATA_W = 64;
    localparam int ADDR_W = 20;
    localparam int BE_W = 8;
    localparam int SPACE_N = 4;
    localparam int SPACE_W = 2;
    localparam int REG_AW = 8;
    localparam int REG_DW = 32;
    localparam int CNT_W = 3;
    localparam int LAT_W = 2;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [REG_AW-1:0] OFF_SEC [SPACE_N] = '{8'h00, 8'h04, 8'h08, 8'h0C};
    localparam logic [REG_AW-1:0] OFF_STATUS = 8'h10;

    // Secondary control fields
    localparam int SEC_W = 7;
    localparam int RL_LSB = 0;
    localparam int WL_LSB = 2;
    localparam int CHIP_ENABLE_EXTEND_BIT = 4;
    localparam int STRB_BIT = 5;
    localparam int CLKSEL_BIT = 6;
    localparam logic [SEC_W-1:0] SEC_RESET = 7'h00;

    // Status fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_SPACE_LSB = 1;
    localparam int STAT_WRITE_BIT = 3;

    // ****************************************************************
    // Sequencer states
    // ****************************************************************
    typedef enum logic [1:0] {ST_IDLE, ST_ACT, ST_DESEL} psm_state_e;

endpackage : psm_pkg

// *** test/psm_mem_model.sv ***
// Behavioural synchronous memory on the far side of the port
module psm_mem_model
    import psm_pkg::*;
(
    input wire logic mem_clk,
    input wire logic [LAT_W-1:0] rd_lat,
    input wire logic [LAT_W-1:0] wr_lat,
    input wire logic [SPACE_N-1:0] space_chip_enable_n,
    input wire logic [BE_W-1:0] byte_enable_n,
    input wire logic [ADDR_W-1:0] ext_address,
    input wire logic [DATA_W-1:0] ext_data,
    input wire logic ext_data_oe,
    input wire logic strobe_read_enable_n,
    input wire logic sync_write_enable_n,
    output logic [DATA_W-1:0] mem_dq
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [DATA_W-1:0] mem [16];
    logic [BE_W-1:0] be_n;
    logic [3:0] idx;
    logic is_wr = 1'b0;
    int cnt = -1;

    initial
    begin
        mem_dq = '0;
        foreach (mem[i]) mem[i] = '0;
    end

    // Sampled mid-period, once pins launched after the rising edge have settled
    always @(negedge mem_clk)
    begin
        if (cnt < 0 && !(&space_chip_enable_n) && !(sync_write_enable_n && strobe_read_enable_n))
        begin
            cnt = 0;
            is_wr = !sync_write_enable_n;
            idx = ext_address[3:0];
            be_n = byte_enable_n;
        end
        if (cnt >= 0 && is_wr && cnt == int'(wr_lat))
        begin
            // Undriven data pins store garbage, so a missing drive shows on read-back
            for (int b = 0; b < BE_W; b++)
                if (!be_n[b]) mem[idx][b*8 +: 8] = ext_data_oe ? ext_data[b*8 +: 8] : ~ext_data[b*8 +: 8];
            cnt = -1;
        end
        else if (cnt >= 0 && !is_wr && cnt == int'(rd_lat))
            mem_dq = mem[idx];
        else
        begin
            // A released bus never keeps showing the last word
            mem_dq = ~mem_dq;
            if (!is_wr && cnt > int'(rd_lat))
                cnt = -1;
        end
        if (cnt >= 0)
            cnt++;
    end
endmodule : psm_mem_model

// *** test/tb_top.sv ***
// Self-checking bench for the programmable synchronous memory port
module tb_top
    import psm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst, reg_wr, reg_rd, req_valid, req_write, clk_one, clk_two, sel_two, cur_wr;
    logic [REG_AW-1:0] reg_addr;
    logic [REG_DW-1:0] reg_wdata, reg_rdata, rd;
    logic [SPACE_W-1:0] req_space;
    logic [ADDR_W-1:0] req_addr, ea, a;
    logic [BE_W-1:0] req_be, be_n, be;
    logic [DATA_W-1:0] req_wdata, rsp_rdata, d_o, d_m, d, d_w;
    logic req_ready, rsp_valid, d_oe, strb_n, oe_n, we_n;
    logic [SPACE_N-1:0] ce_n;
    logic [LAT_W-1:0] rl, wl;
    logic [99:0] pins_q;
    logic [SEC_W-1:0] cfg [SPACE_N];
    logic [DATA_W-1:0] shadow [16];
    int n_errors = 0, check_count = 0, cyc = 0, cur_sp = 0, sp;
    int t_rise [2] = '{default: 0};
    int cnt [5] = '{default: 0};
    int base [5];
    wire mem_clk = sel_two ? clk_two : clk_one;
    // Wire level of the shared data pins
    assign d_w = d_oe ? d_o : d_m;

    psm_port psm_port_i (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid), .req_write(req_write),
        .req_space(req_space), .req_addr(req_addr), .req_be(req_be), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .ext_clock_out_one(clk_one),
        .ext_clock_out_two(clk_two), .space_chip_enable_n(ce_n), .byte_enable_n(be_n), .ext_address(ea),
        .ext_data_i(d_w), .ext_data_o(d_o), .ext_data_oe(d_oe), .strobe_read_enable_n(strb_n),
        .sync_output_enable_n(oe_n), .sync_write_enable_n(we_n));
    psm_mem_model psm_mem_model_i (.mem_clk(mem_clk), .rd_lat(rl), .wr_lat(wl), .space_chip_enable_n(ce_n),
        .byte_enable_n(be_n), .ext_address(ea), .ext_data(d_w), .ext_data_oe(d_oe),
        .strobe_read_enable_n(strb_n), .sync_write_enable_n(we_n), .mem_dq(d_m));

    // ****************************************************************
    // Clocks, pin monitor and helpers
    // ****************************************************************
    // Link clocks 40 ns apart in phase, so a port timed to the wrong one shows late pins
    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        clk_one = 0;
        #3;
        forever #80 clk_one = ~clk_one;
    end
    initial
    begin
        clk_two = 0;
        #43;
        forever #80 clk_two = ~clk_two;
    end
    // Rise times kept per clock: the model's clock mux can hide a rise when the selection flips
    always @(posedge clk_one) t_rise[0] = int'($time);
    always @(posedge clk_two) t_rise[1] = int'($time);

    // Pin changes must trail the chosen clock's rise; low-time counts feed per-access checks
    always @(posedge clk)
    begin
        cyc++;
        if (!rst && {ce_n, be_n, ea, d_o, d_oe, strb_n, oe_n, we_n} !== pins_q && int'($time) - t_rise[sel_two] > 70)
        begin
            $display("[ERR] t=%0t late pin change %h %h", $time, int'($time) - t_rise[sel_two], 70);
            n_errors++;
        end
        if (!rst && !cur_wr && cfg[cur_sp][CHIP_ENABLE_EXTEND_BIT] && ce_n[cur_sp] !== oe_n)
        begin
            $display("[ERR] t=%0t ce %h oe %h", $time, ce_n, oe_n);
            n_errors++;
        end
        pins_q = {ce_n, be_n, ea, d_o, d_oe, strb_n, oe_n, we_n};
        cnt[0] += !ce_n[cur_sp];
        cnt[1] += !oe_n;
        cnt[2] += !we_n;
        cnt[3] += !strb_n;
        cnt[4] += d_oe;
        if (cyc == 40000)
        begin
            n_errors++;
            finish_test();
        end
    end

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        check_count++;
        if (got !== exp)
        begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask : chk

    // Cycles each pin is low (data enable: high) per access, at 16 clk per link period
    function automatic int exp_cnt(input int k, input logic wr, input logic [SEC_W-1:0] c);
        int lat;
        lat = 16 * (int'(c[RL_LSB +: LAT_W]) + 1);
        case (k)
            0: return (wr || !c[CHIP_ENABLE_EXTEND_BIT]) ? 16 : lat;
            1: return wr ? 0 : lat;
            2: return wr ? 16 : 0;
            3: return c[STRB_BIT] ? (wr ? 0 : 16) : 32;
            default: return wr ? 16 : 0;
        endcase
    endfunction : exp_cnt

    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o, n, input logic [BE_W-1:0] m);
        for (int b = 0; b < BE_W; b++)
            if (m[b]) o[b*8 +: 8] = n[b*8 +: 8];
        return o;
    endfunction : merge

    task automatic reg_write(input logic [REG_AW-1:0] ad, input logic [REG_DW-1:0] wd);
        reg_addr <= ad;
        reg_wdata <= wd;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : reg_write

    task automatic reg_read(input logic [REG_AW-1:0] ad);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        rd = reg_rdata;
    endtask : reg_read

    task automatic access(input logic wr);
        int w;
        cur_sp = sp;
        cur_wr = wr;
        sel_two = cfg[sp][CLKSEL_BIT];
        rl = cfg[sp][RL_LSB +: LAT_W];
        wl = cfg[sp][WL_LSB +: LAT_W];
        base = cnt;
        req_valid <= 1'b1;
        req_write <= wr;
        req_space <= SPACE_W'(sp);
        req_addr <= a;
        req_be <= be;
        req_wdata <= d;
        w = 0;
        do
        begin
            @(posedge clk);
            w++;
        end
        while (req_ready !== 1'b1 && w < 300);
        chk(DATA_W'(req_ready), DATA_W'(1'b1));
        req_valid <= 1'b0;
        w = 0;
        while (!wr && rsp_valid !== 1'b1 && w < 300)
        begin
            @(posedge clk);
            w++;
        end
        if (!wr)
        begin
            chk(DATA_W'(rsp_valid), DATA_W'(1'b1));
            chk(rsp_rdata, shadow[a[3:0]]);
        end
        w = 0;
        do
        begin
            reg_read(OFF_STATUS);
            w++;
        end
        while (rd[STAT_BUSY_BIT] !== 1'b0 && w < 50);
        // Idle again, still showing the space and direction of this access
        chk(DATA_W'(rd), DATA_W'((32'(wr) << STAT_WRITE_BIT) | (32'(sp) << STAT_SPACE_LSB)));
        repeat (2) @(posedge clk);
        for (int k = 0; k < 5; k++)
            chk(cnt[k] - base[k], exp_cnt(k, wr, cfg[sp]));
    endtask : access

    task automatic finish_test();
        if (n_errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        {reg_wr, reg_rd, req_valid, req_write, sel_two, cur_wr, rl, wl} = '0;
        {reg_addr, reg_wdata, req_space, req_addr, req_be, req_wdata} = '0;
        {a, be, d} = '0;
        rst = 1'b1;
        foreach (shadow[i]) shadow[i] = '0;
        foreach (cfg[i]) cfg[i] = '0;
        void'($urandom(32'hc9cb89a3));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // Reset words, read-only status and an unmapped hole
        foreach (cfg[s])
        begin
            reg_read(OFF_SEC[s]);
            chk(rd, 32'h0000_0000);
        end
        reg_write(OFF_STATUS, 32'hffff_ffff);
        reg_read(OFF_STATUS);
        chk(rd, 32'h0000_0000);
        reg_read(8'h14);
        chk(rd, 32'h0000_0000);
        // Each space keeps its own word; bits above the fields read as zero
        foreach (cfg[s]) reg_write(OFF_SEC[s], 32'hffff_ff80 | 32'(17 * (s + 1)));
        foreach (cfg[s])
        begin
            reg_read(OFF_SEC[s]);
            chk(rd, 32'(17 * (s + 1)));
        end
        // First 16 rounds sweep every read/write latency pair, the rest are free
        for (int i = 0; i < 28; i++)
        begin
            sp = $urandom_range(0, 3);
            foreach (cfg[s]) cfg[s] = SEC_W'($urandom);
            if (i < 16)
                cfg[sp][3:0] = 4'(i);
            foreach (cfg[s]) reg_write(OFF_SEC[s], 32'(cfg[s]));
            a = ADDR_W'($urandom);
            be = BE_W'($urandom);
            d = {$urandom, $urandom};
            access(1'b1);
            shadow[a[3:0]] = merge(shadow[a[3:0]], d, be);
            access(1'b0);
        end
        finish_test();
    end
endmodule : tb_top
